//--- hw/nfcbr_cfg.sv
// Purpose: bit rate and type A framing configuration registers with per-frame snapshots
// Assumes: single 125 MHz clock, strobes synchronous, commands are one-cycle pulses
// Notes:   framer sees only the snapshot, so register writes never tear a frame

`timescale 1ns/10ps

// How it works
// - The upper four bits of the speed register pick the transmit bit rate.
// - The lower four bits pick the receive bit rate where the protocol allows it to differ.
// - Speed codes 0 to 3 mean fc/128, fc/64, fc/32 and fc/16; other codes are unused.
// - An unsupported speed code disables both transmit and receive.
// - Both registers clear to zero at power-up and on the restore-defaults command.
// - The normal mode entry command loads the speed register without a software write.
// - The no-transmit-parity bit makes the transmitter send FIFO data with no parity bits.
// - The raw receive bit puts the raw bit stream in the FIFO with no parity or CRC check.
// - The wrap bit adds an F0 start byte and a length byte on transmit and drops F0 on receive.
// - Bits 4 to 1 hold the pause width code, counted in carrier periods.
// - At fc/128 the pause is 35 periods plus the signed code, 27 to 42.
// - At fc/64 the pause follows a folded table from 12 to 22 periods.
// - At fc/32 the pause is 9 plus the signed code, and at fc/16 it is 5 plus it.
module nfcbr_cfg #(
    parameter logic [7:0] NORMAL_RATE_LOAD = 8'h00
) (
    // Clock and reset
    input  wire logic                    CORE_CLK,
    input  wire logic                    RESETN,
    // Register port
    input  wire logic [5:0]              ADDR,
    input  wire logic [7:0]              WR_DATA,
    input  wire logic                    WR_STB,
    input  wire logic                    RD_STB,
    output logic      [7:0]              RD_DATA,
    // Direct commands
    input  wire logic                    SET_DEFAULT,
    input  wire logic                    NORMAL_MODE_ENTRY,
    // Frame starts from the framer
    input  wire logic                    TX_FRAME_START,
    input  wire logic                    RX_FRAME_START,
    // Settings for the framer
    output nfcbr_pkg::nfcbr_tx_cfg_t     TX_CFG,
    output nfcbr_pkg::nfcbr_rx_cfg_t     RX_CFG
);

    // A load value with an unused code would silently switch the link off
    if (NORMAL_RATE_LOAD[7:4] > nfcbr_pkg::RATE_FC16 ||
        NORMAL_RATE_LOAD[3:0] > nfcbr_pkg::RATE_FC16) begin : g_bad_load
        $error("NORMAL_RATE_LOAD holds an unsupported speed code");
    end

    nfcbr_pkg::nfcbr_state_t st_r;
    nfcbr_pkg::nfcbr_state_t st_nxt;

    logic [3:0] tx_code;
    logic [3:0] rx_code;
    logic       rates_ok;
    logic [5:0] pw_width;
    logic       pw_ok;

    assign tx_code  = st_r.speed[nfcbr_pkg::TX_RATE_MSB:nfcbr_pkg::TX_RATE_LSB];
    assign rx_code  = st_r.speed[nfcbr_pkg::RX_RATE_MSB:nfcbr_pkg::RX_RATE_LSB];
    assign rates_ok = (tx_code <= nfcbr_pkg::RATE_FC16) && (rx_code <= nfcbr_pkg::RATE_FC16);

    nfcbr_pulse_decode u_pulse (
        .rate  (tx_code),
        .code  (st_r.framing[nfcbr_pkg::PULSE_LEN_MSB:nfcbr_pkg::PULSE_LEN_LSB]),
        .width (pw_width),
        .ok    (pw_ok)
    );

    always_comb begin
        st_nxt         = st_r;
        st_nxt.rd_data = 8'h00;

        // Software writes; unmapped offsets are ignored
        if (WR_STB) begin
            case (ADDR)
                nfcbr_pkg::LINK_SPEED_OFS:    st_nxt.speed   = WR_DATA;
                nfcbr_pkg::TYPEA_FRAMING_OFS: st_nxt.framing = WR_DATA;
                default:                      st_nxt.speed   = st_nxt.speed;
            endcase
        end

        if (NORMAL_MODE_ENTRY) begin
            st_nxt.speed = NORMAL_RATE_LOAD;
        end

        if (SET_DEFAULT) begin
            st_nxt.speed   = nfcbr_pkg::LINK_SPEED_RST;
            st_nxt.framing = nfcbr_pkg::TYPEA_FRAMING_RST;
        end

        // Reads answer next cycle; unmapped reads give zero
        if (RD_STB) begin
            case (ADDR)
                nfcbr_pkg::LINK_SPEED_OFS:    st_nxt.rd_data = st_r.speed;
                nfcbr_pkg::TYPEA_FRAMING_OFS: st_nxt.rd_data = st_r.framing;
                nfcbr_pkg::CFG_STATUS_OFS:
                    st_nxt.rd_data = {st_r.tx.enable, st_r.rx.enable, st_r.tx.pulse_ok,
                                      rates_ok, pw_ok, 3'h0};
                default:                      st_nxt.rd_data = 8'h00;
            endcase
        end

        if (TX_FRAME_START) begin
            st_nxt.tx.enable      = rates_ok;
            st_nxt.tx.rate        = tx_code;
            st_nxt.tx.no_parity   = st_r.framing[nfcbr_pkg::NO_TX_PAR_BIT];
            st_nxt.tx.wrap        = st_r.framing[nfcbr_pkg::FRAME_WRAP_BIT];
            st_nxt.tx.marker      = st_r.framing[nfcbr_pkg::FRAME_WRAP_BIT] ?
                                    nfcbr_pkg::START_MARKER_BYTE : 8'h00;
            st_nxt.tx.anticoll    = st_r.framing[nfcbr_pkg::ANTICOLL_BIT];
            st_nxt.tx.pulse_ok    = pw_ok;
            st_nxt.tx.pulse_width = pw_width;
        end

        if (RX_FRAME_START) begin
            st_nxt.rx.enable = rates_ok;
            st_nxt.rx.rate   = rx_code;
            st_nxt.rx.raw    = st_r.framing[nfcbr_pkg::NO_RX_PAR_BIT];
            st_nxt.rx.wrap   = st_r.framing[nfcbr_pkg::FRAME_WRAP_BIT];
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESETN) begin
        if (!RESETN) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign RD_DATA = st_r.rd_data;
    assign TX_CFG  = st_r.tx;
    assign RX_CFG  = st_r.rx;

    // Checks

    sequence s_framing_write;
        WR_STB && ADDR == nfcbr_pkg::TYPEA_FRAMING_OFS && !SET_DEFAULT;
    endsequence

    sequence s_then_tx_start;
        TX_FRAME_START;
    endsequence

    property p_tx_rate_snap;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START |=> TX_CFG.rate == $past(st_r.speed[7:4]);
    endproperty
    a_tx_rate_snap: assert property (p_tx_rate_snap)
        else $error("transmit rate not taken from upper speed bits");

    property p_rx_rate_snap;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RX_FRAME_START |=> RX_CFG.rate == $past(st_r.speed[3:0]);
    endproperty
    a_rx_rate_snap: assert property (p_rx_rate_snap)
        else $error("receive rate not taken from lower speed bits");

    property p_good_code_enables;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START && st_r.speed[7:4] <= 4'h3 && st_r.speed[3:0] <= 4'h3
        |=> TX_CFG.enable;
    endproperty
    a_good_code_enables: assert property (p_good_code_enables)
        else $error("supported speed codes did not enable transmit");

    property p_bad_code_disables;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RX_FRAME_START && (st_r.speed[7:4] > 4'h3 || st_r.speed[3:0] > 4'h3)
        |=> !RX_CFG.enable;
    endproperty
    a_bad_code_disables: assert property (p_bad_code_disables)
        else $error("unsupported speed code left receive enabled");

    property p_set_default;
        @(posedge CORE_CLK) disable iff (!RESETN)
        SET_DEFAULT |=> st_r.speed == 8'h00 && st_r.framing == 8'h00;
    endproperty
    a_set_default: assert property (p_set_default)
        else $error("restore defaults did not clear both registers");

    property p_normal_load;
        @(posedge CORE_CLK) disable iff (!RESETN)
        NORMAL_MODE_ENTRY && !SET_DEFAULT |=> st_r.speed == NORMAL_RATE_LOAD;
    endproperty
    a_normal_load: assert property (p_normal_load)
        else $error("normal mode entry did not load the speed register");

    property p_no_parity_path;
        @(posedge CORE_CLK) disable iff (!RESETN)
        s_framing_write ##1 s_then_tx_start |=> TX_CFG.no_parity == $past(WR_DATA[7], 2);
    endproperty
    a_no_parity_path: assert property (p_no_parity_path)
        else $error("written parity suppression not seen at next frame");

    property p_raw_rx;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RX_FRAME_START |=> RX_CFG.raw == $past(st_r.framing[6]);
    endproperty
    a_raw_rx: assert property (p_raw_rx)
        else $error("raw receive bit not applied at frame start");

    property p_marker;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START |=> (TX_CFG.marker == 8'hF0) == TX_CFG.wrap;
    endproperty
    a_marker: assert property (p_marker)
        else $error("start marker byte does not follow the wrap bit");

    property p_pw_fc128;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START && st_r.speed[7:4] == 4'h0
        |=> TX_CFG.pulse_ok &&
            TX_CFG.pulse_width == 6'(7'sd35 + 7'($signed($past(st_r.framing[4:1]))));
    endproperty
    a_pw_fc128: assert property (p_pw_fc128)
        else $error("fc/128 pause width is not 35 plus signed code");

    property p_pw_fc64_range;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_CFG.pulse_ok && TX_CFG.rate == 4'h1
        |-> TX_CFG.pulse_width >= 6'd12 && TX_CFG.pulse_width <= 6'd22;
    endproperty
    a_pw_fc64_range: assert property (p_pw_fc64_range)
        else $error("fc/64 pause width outside 12 to 22");

    property p_pw_fc16_range;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_CFG.pulse_ok && TX_CFG.rate == 4'h3
        |-> TX_CFG.pulse_width >= 6'd2 && TX_CFG.pulse_width <= 6'd8;
    endproperty
    a_pw_fc16_range: assert property (p_pw_fc16_range)
        else $error("fc/16 pause width outside 2 to 8");

    property p_hold_in_frame;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !TX_FRAME_START [*2] |-> $stable(TX_CFG);
    endproperty
    a_hold_in_frame: assert property (p_hold_in_frame)
        else $error("transmit settings changed with no frame start");

    property p_read_latency;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RD_STB && ADDR == nfcbr_pkg::LINK_SPEED_OFS |=> RD_DATA == $past(st_r.speed);
    endproperty
    a_read_latency: assert property (p_read_latency)
        else $error("speed register read back wrong");

    property p_tx_bad_disables;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START && (st_r.speed[7:4] > 4'h3 || st_r.speed[3:0] > 4'h3)
        |=> !TX_CFG.enable;
    endproperty
    a_tx_bad_disables: assert property (p_tx_bad_disables)
        else $error("unsupported speed code left transmit enabled");

    property p_rx_good_enables;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RX_FRAME_START && st_r.speed[7:4] <= 4'h3 && st_r.speed[3:0] <= 4'h3
        |=> RX_CFG.enable;
    endproperty
    a_rx_good_enables: assert property (p_rx_good_enables)
        else $error("supported speed codes did not enable receive");

    property p_rx_hold_in_frame;
        @(posedge CORE_CLK) disable iff (!RESETN)
        !RX_FRAME_START [*2] |-> $stable(RX_CFG);
    endproperty
    a_rx_hold_in_frame: assert property (p_rx_hold_in_frame)
        else $error("receive settings changed with no frame start");

    property p_tx_wrap;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START |=> TX_CFG.wrap == $past(st_r.framing[5]);
    endproperty
    a_tx_wrap: assert property (p_tx_wrap)
        else $error("transmit wrap bit not applied at frame start");

    property p_rx_wrap;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RX_FRAME_START |=> RX_CFG.wrap == $past(st_r.framing[5]);
    endproperty
    a_rx_wrap: assert property (p_rx_wrap)
        else $error("receive wrap bit not applied at frame start");

    // Commands take the speed register, so only a lone write must land
    property p_speed_write;
        @(posedge CORE_CLK) disable iff (!RESETN)
        WR_STB && ADDR == nfcbr_pkg::LINK_SPEED_OFS && !SET_DEFAULT && !NORMAL_MODE_ENTRY
        |=> st_r.speed == $past(WR_DATA);
    endproperty
    a_speed_write: assert property (p_speed_write)
        else $error("written speed codes not stored");

    property p_framing_write;
        @(posedge CORE_CLK) disable iff (!RESETN)
        s_framing_write |=> st_r.framing == $past(WR_DATA);
    endproperty
    a_framing_write: assert property (p_framing_write)
        else $error("written framing options not stored");

    property p_pw_fc64_fold;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START && st_r.speed[7:4] == 4'h1 && st_r.framing[4:1] == 4'h4
        |=> TX_CFG.pulse_ok && TX_CFG.pulse_width == 6'd22;
    endproperty
    a_pw_fc64_fold: assert property (p_pw_fc64_fold)
        else $error("fc/64 code 0100 did not give 22 periods");

    property p_pw_fc64_gap;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_FRAME_START && st_r.speed[7:4] == 4'h1 &&
        st_r.framing[4:1] inside {4'h7, 4'h8, 4'h9}
        |=> !TX_CFG.pulse_ok;
    endproperty
    a_pw_fc64_gap: assert property (p_pw_fc64_gap)
        else $error("undefined fc/64 pause code reported as valid");

    property p_pw_fc32_range;
        @(posedge CORE_CLK) disable iff (!RESETN)
        TX_CFG.pulse_ok && TX_CFG.rate == 4'h2
        |-> TX_CFG.pulse_width >= 6'd5 && TX_CFG.pulse_width <= 6'd13;
    endproperty
    a_pw_fc32_range: assert property (p_pw_fc32_range)
        else $error("fc/32 pause width outside 5 to 13");

    property p_read_framing;
        @(posedge CORE_CLK) disable iff (!RESETN)
        RD_STB && ADDR == nfcbr_pkg::TYPEA_FRAMING_OFS |=> RD_DATA == $past(st_r.framing);
    endproperty
    a_read_framing: assert property (p_read_framing)
        else $error("framing register read back wrong");

endmodule : nfcbr_cfg

//--- hw/nfcbr_pkg.sv
// Purpose: shared constants and carrier types for the bit rate and type A framing registers
// Assumes: 8-bit register port, one 125 MHz core clock
// Notes:   speed codes and pulse width bases are the hardware's coding

package nfcbr_pkg;

    // Register port geometry
    localparam int          ADDR_W            = 6;
    localparam int          DATA_W            = 8;

    // Register offsets
    localparam logic [5:0]  LINK_SPEED_OFS    = 6'h04;
    localparam logic [5:0]  TYPEA_FRAMING_OFS = 6'h05;
    localparam logic [5:0]  CFG_STATUS_OFS    = 6'h20;

    // Values after power-up and after restore defaults
    localparam logic [7:0]  LINK_SPEED_RST    = 8'h00;
    localparam logic [7:0]  TYPEA_FRAMING_RST = 8'h00;

    // Field positions in link_speed_select
    localparam int          TX_RATE_MSB       = 7;
    localparam int          TX_RATE_LSB       = 4;
    localparam int          RX_RATE_MSB       = 3;
    localparam int          RX_RATE_LSB       = 0;

    // Field positions in typea_framing_options
    localparam int          NO_TX_PAR_BIT     = 7;
    localparam int          NO_RX_PAR_BIT     = 6;
    localparam int          FRAME_WRAP_BIT    = 5;
    localparam int          PULSE_LEN_MSB     = 4;
    localparam int          PULSE_LEN_LSB     = 1;
    localparam int          ANTICOLL_BIT      = 0;

    // Speed codes; every other code is unsupported
    localparam logic [3:0]  RATE_FC128        = 4'h0;
    localparam logic [3:0]  RATE_FC64         = 4'h1;
    localparam logic [3:0]  RATE_FC32         = 4'h2;
    localparam logic [3:0]  RATE_FC16         = 4'h3;

    // Pulse width bases in carrier periods, code read as signed offset
    localparam logic signed [6:0] PW_BASE_FC128 = 7'sh23;
    localparam logic signed [6:0] PW_BASE_FC64  = 7'sh12;
    localparam logic signed [6:0] PW_BASE_FC32  = 7'sh09;
    localparam logic signed [6:0] PW_BASE_FC16  = 7'sh05;
    localparam logic signed [4:0] PW_FC32_MIN   = -5'sh4;
    localparam logic signed [4:0] PW_FC32_MAX   = 5'sh4;
    localparam logic signed [4:0] PW_FC16_MIN   = -5'sh3;
    localparam logic signed [4:0] PW_FC16_MAX   = 5'sh3;
    localparam logic signed [4:0] PW_FC64_MIN   = -5'sh6;

    // Transport frame start marker
    localparam logic [7:0]  START_MARKER_BYTE = 8'hF0;

    // Settings handed to the transmitter, frozen at frame start
    typedef struct packed {
        logic       enable;
        logic [3:0] rate;
        logic       no_parity;
        logic       wrap;
        logic       anticoll;
        logic       pulse_ok;
        logic [5:0] pulse_width;
        logic [7:0] marker;
    } nfcbr_tx_cfg_t;

    // Settings handed to the receiver, frozen at frame start
    typedef struct packed {
        logic       enable;
        logic [3:0] rate;
        logic       raw;
        logic       wrap;
    } nfcbr_rx_cfg_t;

    // Whole state of the register bank
    typedef struct packed {
        logic [7:0]    speed;
        logic [7:0]    framing;
        logic [7:0]    rd_data;
        nfcbr_tx_cfg_t tx;
        nfcbr_rx_cfg_t rx;
    } nfcbr_state_t;

endpackage : nfcbr_pkg

//--- hw/nfcbr_pulse_decode.sv
// Purpose: decode the type A pause width code into carrier periods for a speed code
// Assumes: purely combinational, inputs from registers
// Notes:   ok is low for codes the chosen rate does not define

`timescale 1ns/10ps

module nfcbr_pulse_decode (
    // Selection
    input  wire logic [3:0] rate,
    input  wire logic [3:0] code,
    // Result
    output logic      [5:0] width,
    output logic            ok
);

    logic signed [4:0] offs;
    logic signed [6:0] sum;

    always_comb begin
        offs  = 5'($signed(code));
        sum   = 7'sh00;
        ok    = 1'b0;
        case (rate)
            nfcbr_pkg::RATE_FC128: begin
                sum = nfcbr_pkg::PW_BASE_FC128 + 7'(offs);
                ok  = 1'b1;
            end
            nfcbr_pkg::RATE_FC64: begin
                if (offs > 5'sh3) begin
                    // Upper codes fold back: 6 gives 20, 4 gives 22
                    sum = nfcbr_pkg::PW_BASE_FC64 + 7'sh08 - 7'(offs);
                    ok  = (offs != 5'sh7);
                end else begin
                    sum = nfcbr_pkg::PW_BASE_FC64 + 7'(offs);
                    ok  = (offs >= nfcbr_pkg::PW_FC64_MIN);
                end
            end
            nfcbr_pkg::RATE_FC32: begin
                sum = nfcbr_pkg::PW_BASE_FC32 + 7'(offs);
                ok  = (offs >= nfcbr_pkg::PW_FC32_MIN) && (offs <= nfcbr_pkg::PW_FC32_MAX);
            end
            nfcbr_pkg::RATE_FC16: begin
                sum = nfcbr_pkg::PW_BASE_FC16 + 7'(offs);
                ok  = (offs >= nfcbr_pkg::PW_FC16_MIN) && (offs <= nfcbr_pkg::PW_FC16_MAX);
            end
            default: begin
                sum = 7'sh00;
                ok  = 1'b0;
            end
        endcase
        width = ok ? sum[5:0] : 6'h00;
    end

endmodule : nfcbr_pulse_decode

//--- testbench/nfcbr_cfg_bench.sv
// Purpose: self-checking bench for the speed and type A framing registers
// Assumes: normal mode entry loads speed 12h here
// Notes:   pulse widths are worked out from the signed code, not from the decoder

`timescale 1ns/10ps

module nfcbr_cfg_bench;
    localparam logic [7:0] NORMAL_LOAD = 8'h12;
    // Speed 21h, framing E1h: fc/32 transmit, code 0 gives 9 periods
    localparam logic [22:0] TX_FIRST = {1'b1, 4'h2, 4'hF, 6'd9, 8'hF0};

    logic                     CORE_CLK;
    logic                     RESETN;
    logic [5:0]               ADDR;
    logic [7:0]               WR_DATA;
    logic                     WR_STB;
    logic                     RD_STB;
    logic [7:0]               RD_DATA;
    logic                     SET_DEFAULT;
    logic                     NORMAL_MODE_ENTRY;
    logic                     TX_FRAME_START;
    logic                     RX_FRAME_START;
    nfcbr_pkg::nfcbr_tx_cfg_t TX_CFG;
    nfcbr_pkg::nfcbr_rx_cfg_t RX_CFG;
    nfcbr_pkg::nfcbr_tx_cfg_t tx_seen;
    nfcbr_pkg::nfcbr_rx_cfg_t rx_seen;
    nfcbr_pkg::nfcbr_tx_cfg_t exp_tx;
    logic                     tx_go;
    logic                     rx_go;
    int                       err_count;
    int                       checks_done;

    nfcbr_cfg #(.NORMAL_RATE_LOAD(NORMAL_LOAD)) dut_u (
        .CORE_CLK(CORE_CLK), .RESETN(RESETN), .ADDR(ADDR), .WR_DATA(WR_DATA),
        .WR_STB(WR_STB), .RD_STB(RD_STB), .RD_DATA(RD_DATA), .SET_DEFAULT(SET_DEFAULT),
        .NORMAL_MODE_ENTRY(NORMAL_MODE_ENTRY), .TX_FRAME_START(TX_FRAME_START),
        .RX_FRAME_START(RX_FRAME_START), .TX_CFG(TX_CFG), .RX_CFG(RX_CFG)
    );

    nfcbr_framer_model framer_u (
        .clk(CORE_CLK), .rst_n(RESETN), .tx_go(tx_go), .rx_go(rx_go),
        .tx_start(TX_FRAME_START), .rx_start(RX_FRAME_START), .tx_cfg(TX_CFG),
        .rx_cfg(RX_CFG), .tx_seen(tx_seen), .rx_seen(rx_seen)
    );

    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end

    // Expected {ok, width}; undefined codes give zero
    function automatic logic [6:0] pw_exp(input logic [3:0] r, input logic [3:0] c);
        int s;
        s = c[3] ? int'(c) - 16 : int'(c);
        case (r)
            4'h0: return {1'b1, 6'(35 + s)};
            4'h1: if (c inside {4'h7, 4'h8, 4'h9}) return 7'h00;
                  else return {1'b1, 6'((s >= 4) ? 26 - s : 18 + s)};
            4'h2: return (s >= -4 && s <= 4) ? {1'b1, 6'(9 + s)} : 7'h00;
            4'h3: return (s >= -3 && s <= 3) ? {1'b1, 6'(5 + s)} : 7'h00;
            default: return 7'h00;
        endcase
    endfunction : pw_exp

    task automatic check(input string what, input logic [31:0] ev, input logic [31:0] got);
        checks_done++;
        if (got !== ev) begin
            err_count++;
            $display("[ERR] %s expected %0h seen %0h", what, ev, got);
        end
    endtask : check

    task automatic reg_wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge CORE_CLK);
        ADDR    <= a;
        WR_DATA <= d;
        WR_STB  <= 1'b1;
        @(posedge CORE_CLK);
        WR_STB  <= 1'b0;
    endtask : reg_wr

    task automatic rd_chk(input string what, input logic [5:0] a, input logic [7:0] e);
        @(posedge CORE_CLK);
        ADDR   <= a;
        RD_STB <= 1'b1;
        @(posedge CORE_CLK);
        RD_STB <= 1'b0;
        #1;
        check(what, {24'h0, e}, {24'h0, RD_DATA});
    endtask : rd_chk

    task automatic command(input logic dflt);
        @(posedge CORE_CLK);
        SET_DEFAULT       <= dflt;
        NORMAL_MODE_ENTRY <= ~dflt;
        @(posedge CORE_CLK);
        SET_DEFAULT       <= 1'b0;
        NORMAL_MODE_ENTRY <= 1'b0;
    endtask : command

    // One request pulse, then the one-cycle answer after the model's start pulse
    task automatic frame(input logic tx, input logic rx);
        @(posedge CORE_CLK);
        tx_go <= tx;
        rx_go <= rx;
        @(posedge CORE_CLK);
        tx_go <= 1'b0;
        rx_go <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        #1;
    endtask : frame

    task automatic give_verdict;
        $display("Checks made %0d, mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20000) @(posedge CORE_CLK);
        err_count++;
        give_verdict();
    end

    initial begin
        {RESETN, WR_STB, RD_STB, SET_DEFAULT, NORMAL_MODE_ENTRY, tx_go, rx_go} = '0;
        ADDR        = 6'h00;
        WR_DATA     = 8'h00;
        err_count   = 0;
        checks_done = 0;
        repeat (2) @(posedge CORE_CLK);
        RESETN <= 1'b1;
        rd_chk("speed_rst", nfcbr_pkg::LINK_SPEED_OFS, 8'h00);
        rd_chk("framing_rst", nfcbr_pkg::TYPEA_FRAMING_OFS, 8'h00);
        reg_wr(nfcbr_pkg::LINK_SPEED_OFS, 8'h21);
        // Anticollision bit set ahead of an anticollision frame, as the host must
        reg_wr(nfcbr_pkg::TYPEA_FRAMING_OFS, 8'hE1);
        rd_chk("speed", nfcbr_pkg::LINK_SPEED_OFS, 8'h21);
        rd_chk("framing", nfcbr_pkg::TYPEA_FRAMING_OFS, 8'hE1);
        rd_chk("unmapped", 6'h10, 8'h00);
        // Type A session: raw receive is legal, the host sends without checksum
        frame(1'b1, 1'b1);
        check("tx_flags", {9'h0, TX_FIRST}, {9'h0, TX_CFG});
        check("rx_flags", {25'h0, 1'b1, 4'h1, 2'b11}, {25'h0, RX_CFG});
        check("model_tx", {9'h0, TX_FIRST}, {9'h0, tx_seen});
        rd_chk("status", nfcbr_pkg::CFG_STATUS_OFS, 8'hF8);
        reg_wr(nfcbr_pkg::TYPEA_FRAMING_OFS, 8'h00);
        frame(1'b0, 1'b1);
        check("tx_held", {9'h0, TX_FIRST}, {9'h0, TX_CFG});
        check("rx_plain", {25'h0, 1'b1, 4'h1, 2'b00}, {25'h0, rx_seen});
        // Write lands one edge before the frame start, so this frame uses it
        @(posedge CORE_CLK);
        ADDR    <= nfcbr_pkg::TYPEA_FRAMING_OFS;
        WR_DATA <= 8'h80;
        WR_STB  <= 1'b1;
        tx_go   <= 1'b1;
        @(posedge CORE_CLK);
        WR_STB  <= 1'b0;
        tx_go   <= 1'b0;
        repeat (3) @(posedge CORE_CLK);
        #1;
        check("no_par_next", 32'h1, {31'h0, TX_CFG.no_parity});
        command(1'b1);
        rd_chk("speed_dflt", nfcbr_pkg::LINK_SPEED_OFS, 8'h00);
        reg_wr(nfcbr_pkg::TYPEA_FRAMING_OFS, 8'h3C);
        command(1'b1);
        rd_chk("framing_dflt", nfcbr_pkg::TYPEA_FRAMING_OFS, 8'h00);
        command(1'b0);
        rd_chk("speed_load", nfcbr_pkg::LINK_SPEED_OFS, NORMAL_LOAD);
        // Every rate against every pause code
        for (int r = 0; r < 4; r++) begin
            reg_wr(nfcbr_pkg::LINK_SPEED_OFS, {4'(r), 4'(r)});
            for (int c = 0; c < 16; c++) begin
                reg_wr(nfcbr_pkg::TYPEA_FRAMING_OFS, {3'b000, 4'(c), 1'b0});
                frame(1'b1, 1'b0);
                exp_tx        = '0;
                exp_tx.enable = 1'b1;
                exp_tx.rate   = 4'(r);
                {exp_tx.pulse_ok, exp_tx.pulse_width} = pw_exp(4'(r), 4'(c));
                check("tx_pulse", {9'h0, exp_tx}, {9'h0, TX_CFG});
            end
        end
        // Unsupported codes on either side stop both directions
        for (int u = 4; u < 16; u++) begin
            reg_wr(nfcbr_pkg::LINK_SPEED_OFS, {4'(u), 4'h0});
            frame(1'b1, 1'b1);
            check("tx_bad", 32'h0, {30'h0, TX_CFG.enable, RX_CFG.enable});
            reg_wr(nfcbr_pkg::LINK_SPEED_OFS, {4'h3, 4'(u)});
            frame(1'b1, 1'b1);
            check("rx_bad", 32'h0, {30'h0, TX_CFG.enable, RX_CFG.enable});
        end
        give_verdict();
    end
endmodule : nfcbr_cfg_bench

//--- testbench/nfcbr_framer_model.sv
// Purpose: framer model that opens frames and records the settings each frame got
// Assumes: frame requests arrive from the bench as one-cycle pulses
// Notes:   settings are taken one cycle after the start pulse, when they are first valid

`timescale 1ns/10ps

module nfcbr_framer_model (
    // Clock and reset
    input  wire logic                     clk,
    input  wire logic                     rst_n,
    // Requests from the bench
    input  wire logic                     tx_go,
    input  wire logic                     rx_go,
    // Frame starts towards the register bank
    output logic                          tx_start,
    output logic                          rx_start,
    // Settings from the register bank
    input  wire nfcbr_pkg::nfcbr_tx_cfg_t tx_cfg,
    input  wire nfcbr_pkg::nfcbr_rx_cfg_t rx_cfg,
    // Settings as the last frame saw them
    output nfcbr_pkg::nfcbr_tx_cfg_t      tx_seen,
    output nfcbr_pkg::nfcbr_rx_cfg_t      rx_seen
);
    logic tx_wait_r;
    logic rx_wait_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tx_start  <= 1'b0;
            rx_start  <= 1'b0;
            tx_wait_r <= 1'b0;
            rx_wait_r <= 1'b0;
            tx_seen   <= '0;
            rx_seen   <= '0;
        end else begin
            tx_start  <= tx_go;
            rx_start  <= rx_go;
            tx_wait_r <= tx_start;
            rx_wait_r <= rx_start;
            if (tx_wait_r) begin
                tx_seen <= tx_cfg;
            end
            if (rx_wait_r) begin
                rx_seen <= rx_cfg;
            end
        end
    end
endmodule : nfcbr_framer_model
